//--- design/pog_pio_cell.sv
// output register, tri-state register, 1:8 input and 8:1 output gearboxes of a pin pair
// assumes pin-side clocks are far slower than ref_clk so each edge is seen once
//
// Local design decisions: the APB slave port and the placing of the registers.
module pog_pio_cell #(
    parameter bit RIGHT_EDGE = 1'b1
) (
    // system
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core side
    input  wire logic        firstCoreBit,
    input  wire logic        secondCoreBit,
    input  wire logic        tristateCtrlIn,
    input  wire logic        wordAlignReq,
    input  wire logic        gearRst,
    input  wire logic [7:0]  txWord,
    output logic      [7:0]  rxWord,
    output logic             slowClkEn,
    // pin side clocks
    input  wire logic [1:0]  fastEdgeClk,
    input  wire logic        writeStrobeShiftedClk,
    // pads
    output logic             padOut,
    output logic             padOe,
    input  wire logic        serInA,
    input  wire logic        serInC,
    output logic             serOutA,
    output logic             serOutC
);

    pog_pkg::pog_ctrl_type ctrl;
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic [2:0] prevLvl;
    logic       bitEv;
    logic       ioRise;
    logic       ioFall;
    logic       strobeRise;
    logic       memMode;
    logic       riseDataReg;
    logic       secondRise;
    logic       fallDataReg;
    logic       tristateRegOut;
    logic       tsStrobe;
    logic [2:0] bitCnt;
    logic       slipPend;
    logic       wordEnd;
    logic [7:0] txStage1;
    logic [7:0] txStage2;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [7:0] next_rxShift;
    logic [7:0] rxHold;
    logic       apbWrite;

    // two flops per pin input; only stage B is read by logic
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            syncA   <= 5'h00;
            syncB   <= 5'h00;
            prevLvl <= 3'h0;
        end
        else
        begin
            syncA   <= {fastEdgeClk, writeStrobeShiftedClk, serInA, serInC};
            syncB   <= syncA;
            prevLvl <= syncB[4:2];
        end
    end

    // edge clock bit 0 times gearbox bits on both edges, bit 1 clocks the output register
    assign bitEv      = syncB[3] ^ prevLvl[1];
    assign ioRise     = syncB[4] & ~prevLvl[2];
    assign ioFall     = ~syncB[4] & prevLvl[2];
    assign strobeRise = syncB[2] & ~prevLvl[0];
    assign memMode    = (ctrl.outMode == pog_pkg::memory_ddr) && RIGHT_EDGE;

    // apb slave: zero wait states, error on unmapped address
    assign pready   = 1'b1;
    assign apbWrite = psel && penable && pwrite;
    assign pslverr  = psel && penable
                      && paddr != pog_pkg::CTRL_OFFSET && paddr != pog_pkg::STATUS_OFFSET;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl <= pog_pkg::pog_ctrl_type'(pog_pkg::CTRL_RESET[4:0]);
        else if (apbWrite && paddr == pog_pkg::CTRL_OFFSET)
            ctrl <= pog_pkg::pog_ctrl_type'(pwdata[4:0]);
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (paddr == pog_pkg::CTRL_OFFSET)
            prdata[4:0] = ctrl;
        else if (paddr == pog_pkg::STATUS_OFFSET)
        begin
            prdata[pog_pkg::RX_WORD_POS +: 8]  = rxWord;
            prdata[pog_pkg::BIT_CNT_POS +: 3]  = bitCnt;
            prdata[pog_pkg::TS_STATE_POS]      = tristateRegOut;
        end
    end

    // output register block
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            riseDataReg <= 1'b0;
            secondRise  <= 1'b0;
        end
        else if (ctrl.outMode == pog_pkg::single_rate_latch)
        begin
            if (syncB[4])
                riseDataReg <= firstCoreBit;
        end
        else if (ioRise)
        begin
            riseDataReg <= firstCoreBit;
            secondRise  <= secondCoreBit;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            fallDataReg <= 1'b0;
        else if (ioFall)
            fallDataReg <= secondRise;
    end

    // mux select: edge clock level, or write strobe level in memory mode
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            padOut <= 1'b0;
        else if (ctrl.outMode == pog_pkg::single_rate_mode
                 || ctrl.outMode == pog_pkg::single_rate_latch)
            padOut <= riseDataReg;
        else if (memMode)
            padOut <= syncB[2] ? riseDataReg : fallDataReg;
        else
            padOut <= syncB[4] ? riseDataReg : fallDataReg;
    end

    // tri-state register block; high control means buffer off
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            tristateRegOut <= 1'b1;
        else if (ioRise)
            tristateRegOut <= tristateCtrlIn;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            tsStrobe <= 1'b1;
        else if (strobeRise)
            tsStrobe <= tristateRegOut;
    end

    assign padOe = memMode ? ~tsStrobe : ~tristateRegOut;

    // word framing shared by both gearboxes
    assign wordEnd = bitEv && !slipPend && bitCnt == pog_pkg::lastBit(ctrl.gear);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || gearRst)
        begin
            bitCnt   <= pog_pkg::BIT_CNT_INIT;
            slipPend <= 1'b0;
        end
        else
        begin
            if (wordAlignReq)
                slipPend <= 1'b1;
            else if (bitEv)
                slipPend <= 1'b0;
            // a pending slip holds the count for one bit, moving the boundary
            if (bitEv && !slipPend)
                bitCnt <= wordEnd ? pog_pkg::BIT_CNT_INIT : bitCnt + 3'h1;
        end
    end

    // slow core enable at the first bit of each word: core samples rxWord, presents txWord
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || gearRst)
            slowClkEn <= 1'b0;
        else
            slowClkEn <= bitEv && !slipPend && bitCnt == pog_pkg::BIT_CNT_INIT;
    end

    // output gearbox: slow sample, transfer, fast shift
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || gearRst)
        begin
            txStage1 <= pog_pkg::WORD_RESET;
            txStage2 <= pog_pkg::WORD_RESET;
            txShift  <= pog_pkg::WORD_RESET;
        end
        else
        begin
            if (slowClkEn)
                txStage1 <= txWord;
            if (wordEnd)
            begin
                txStage2 <= txStage1;
                txShift  <= txStage2;
            end
            else if (bitEv)
            begin
                if (ctrl.gear == pog_pkg::narrow_ddr_gear_mode)
                    txShift <= {1'b0, txShift[7:5], 1'b0, txShift[3:1]};
                else
                    txShift <= {1'b0, txShift[7:1]};
            end
        end
    end

    // lane A shifts bits 3..0, lane C bits 7..4 in narrow mode
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || gearRst)
        begin
            serOutA <= 1'b0;
            serOutC <= 1'b0;
        end
        else
        begin
            serOutA <= txShift[0];
            serOutC <= ctrl.gear == pog_pkg::narrow_ddr_gear_mode ? txShift[4] : 1'b0;
        end
    end

    // input gearbox: earliest bit ends in the lowest position of its lane
    always_comb
    begin
        next_rxShift = rxShift;
        case (ctrl.gear)
            pog_pkg::video_gear_mode:
                next_rxShift = {1'b0, syncB[1], rxShift[6:1]};
            pog_pkg::narrow_ddr_gear_mode:
                next_rxShift = {syncB[1], rxShift[7:5], syncB[0], rxShift[3:1]};
            default:
                next_rxShift = {syncB[1], rxShift[7:1]};
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || gearRst)
        begin
            rxShift <= pog_pkg::WORD_RESET;
            rxHold  <= pog_pkg::WORD_RESET;
            rxWord  <= pog_pkg::WORD_RESET;
        end
        else
        begin
            if (bitEv)
                rxShift <= next_rxShift;
            if (wordEnd)
                rxHold <= next_rxShift;
            if (slowClkEn)
                rxWord <= rxHold;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_sdr_out_path: assert property (
        ctrl.outMode == pog_pkg::single_rate_mode && $stable(ctrl)
        |=> padOut == $past(riseDataReg))
        else $error("single-rate output not from rise register");
    a_fall_reg_load: assert property (
        ioFall |=> fallDataReg == $past(secondRise))
        else $error("fall register missed second bit");
    a_gddr_mux_sel: assert property (
        ctrl.outMode == pog_pkg::generic_ddr && $stable(ctrl)
        |=> padOut == ($past(syncB[4]) ? $past(riseDataReg) : $past(fallDataReg)))
        else $error("generic mux select wrong");
    a_rise_capture: assert property (
        ioRise && ctrl.outMode != pog_pkg::single_rate_latch
        |=> secondRise == $past(secondCoreBit) && riseDataReg == $past(firstCoreBit))
        else $error("rise capture wrong");
    a_mem_mux_sel: assert property (
        memMode && $stable(ctrl)
        |=> padOut == ($past(syncB[2]) ? $past(riseDataReg) : $past(fallDataReg)))
        else $error("memory mux not on strobe");
    a_ts_enable: assert property (
        !memMode |-> padOe == !tristateRegOut)
        else $error("tri-state enable wrong");
    a_ts_strobe: assert property (
        strobeRise ##1 memMode |-> padOe == !$past(tristateRegOut))
        else $error("strobe tri-state register wrong");
    a_bit_cnt_range: assert property (
        wordEnd |=> bitCnt == pog_pkg::BIT_CNT_INIT)
        else $error("framing counter did not restart at word end");
    a_align_slip: assert property (
        slipPend && bitEv && !wordAlignReq && !gearRst |=> $stable(bitCnt) && !slipPend)
        else $error("align slip did not hold count");
    a_gear_reset: assert property (
        gearRst |=> bitCnt == pog_pkg::BIT_CNT_INIT && txShift == pog_pkg::WORD_RESET
                    && rxShift == pog_pkg::WORD_RESET)
        else $error("gearbox reset incomplete");
    a_rx_word_load: assert property (
        slowClkEn && !gearRst |=> rxWord == $past(rxHold))
        else $error("rx word not loaded from hold stage");

    c_mem_mode: cover property (memMode && strobeRise);
    c_word_end: cover property (wordEnd && ctrl.gear == pog_pkg::narrow_ddr_gear_mode);
    c_align: cover property (wordAlignReq ##[1:40] wordEnd);
    c_apb_err: cover property (pslverr);

endmodule // pog_pio_cell

//--- design/pog_pkg.sv
// constants, types and register map of the per-pin output, tri-state and gearbox block
// assumes one 50 MHz system clock; every pin-side clock is sampled by it
// Overview of operation
// - single-rate output passes first core bit via one register or latch.
// - generic double-rate captures both bits on rise, second re-registered on fall.
// - generic double-rate mux alternates rise and fall registers on same clock.
// - memory double-rate captures both bits on rise, second moved on fall.
// - memory double-rate mux is switched by the shifted write strobe clock.
// - only right-edge blocks offer memory double-rate; other edges fall back.
// - single-rate tri-state control registered once, drives buffer enable.
// - memory mode tri-state passes one more register on write strobe clock.
// - input gearbox works as 1:7, one 1:8 or two independent 1:4.
// - input words on bits 6..0, 7..0; 1:4 lanes on 7..4 and 3..0.
// - input gearbox takes delayed pad data on edge clock; core gives align.
// - align request shifts the deserializer word boundary by one bit.
// - output gearbox works as 7:1, one 8:1 or two independent 4:1.
// - gearbox has slow sample, transfer and fast shift register stages.
package pog_pkg;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // control field positions
    localparam int OUT_MODE_POS  = 0;
    localparam int GEAR_MODE_POS = 2;
    localparam int STROBE_TS_POS = 4;

    // status field positions
    localparam int RX_WORD_POS  = 0;
    localparam int BIT_CNT_POS  = 8;
    localparam int TS_STATE_POS = 11;

    // last bit index of a word per gear mode
    localparam logic [2:0] LAST_BIT_VIDEO  = 3'h6;
    localparam logic [2:0] LAST_BIT_WIDE   = 3'h7;
    localparam logic [2:0] LAST_BIT_NARROW = 3'h3;

    // values after reset
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [7:0]  WORD_RESET   = 8'h00;
    localparam logic [2:0]  BIT_CNT_INIT = 3'h0;

    typedef enum logic [1:0] {
        single_rate_mode,
        single_rate_latch,
        generic_ddr,
        memory_ddr
    } pog_out_mode_type;

    typedef enum logic [1:0] {
        video_gear_mode,
        wide_ddr_gear_mode,
        narrow_ddr_gear_mode,
        spare_gear_mode
    } pog_gear_type;

    typedef struct packed {
        logic             strobeTs;
        pog_gear_type     gear;
        pog_out_mode_type outMode;
    } pog_ctrl_type;

    function automatic logic [2:0] lastBit(input pog_gear_type g);
        case (g)
            video_gear_mode:      lastBit = LAST_BIT_VIDEO;
            narrow_ddr_gear_mode: lastBit = LAST_BIT_NARROW;
            default:              lastBit = LAST_BIT_WIDE;
        endcase
    endfunction

endpackage

//--- bench/pog_pin_partner.sv
// far-side pin device: pin clocks, serial lanes toward the block, capture of serial outputs
// assumes ref_clk is the block's system clock; it is only used to launch pin activity
module pog_pin_partner (
    // system
    input  wire logic       ref_clk,
    // pin clocks and lanes toward the block
    output logic      [1:0] fastEdgeClk,
    output logic            writeStrobeShiftedClk,
    output logic            serInA,
    output logic            serInC,
    // serial lanes from the block
    input  wire logic       serOutA,
    input  wire logic       serOutC
);
    timeunit 1ns;
    timeprecision 1ps;

    logic bitsA [64];
    logic bitsC [64];
    logic capA  [64];
    logic capC  [64];

    initial
    begin
        fastEdgeClk = 2'h0;
        writeStrobeShiftedClk = 1'b0;
        serInA = 1'b0;
        serInC = 1'b1;
    end

    // one bit per edge of the bit clock; data leads each edge by 20 ns and holds 60 ns
    // so that a two-stage synchronizer still sees it; capX[k] holds the bit of event k-1
    task automatic run_frame(input int n);
        @(posedge ref_clk);
        #7;
        for (int k = 0; k < n; k++)
        begin
            serInA = bitsA[k];
            serInC = bitsC[k];
            #20 fastEdgeClk[0] = ~fastEdgeClk[0];
            #40;
            capA[k] = serOutA;
            capC[k] = serOutC;
            #20;
        end
        // released lanes show the inverse of the last bit; the bit clock stands still
        serInA = ~serInA;
        serInC = ~serInC;
    endtask

    // one edge of the register clock or of the shifted write strobe, then settle
    task automatic set_pin_clk(input bit strobe, input bit v);
        @(posedge ref_clk);
        #7;
        if (strobe)
            writeStrobeShiftedClk = v;
        else
            fastEdgeClk[1] = v;
        repeat (8) @(posedge ref_clk);
    endtask

endmodule // pog_pin_partner

//--- bench/tb_top.sv
// self-checking bench of the pin cell: apb, output and tri-state registers, gearboxes
// assumes the partner model drives every pin-side clock and serial lane
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic        firstCoreBit = 1'b0, secondCoreBit = 1'b0, tristateCtrlIn = 1'b1;
    logic        gearRst = 1'b0, wordAlignReq = 1'b0;
    logic [7:0]  txWord = 8'h00;
    logic [7:0]  rxWord;
    logic        slowClkEn, enLate = 1'b0;
    logic [1:0]  fastEdgeClk;
    logic        writeStrobeShiftedClk, serInA, serInC, serOutA, serOutC, padOut, padOe;
    logic [7:0]  rxQ [$];
    logic [7:0]  txSent [$];
    int          fails = 0, comparisons = 0, cycles = 0;

    always #10 ref_clk = ~ref_clk;

    pog_pio_cell #(.RIGHT_EDGE(1'b1)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .firstCoreBit(firstCoreBit),
        .secondCoreBit(secondCoreBit), .tristateCtrlIn(tristateCtrlIn),
        .wordAlignReq(wordAlignReq), .gearRst(gearRst), .txWord(txWord), .rxWord(rxWord),
        .slowClkEn(slowClkEn), .fastEdgeClk(fastEdgeClk),
        .writeStrobeShiftedClk(writeStrobeShiftedClk), .padOut(padOut), .padOe(padOe),
        .serInA(serInA), .serInC(serInC), .serOutA(serOutA), .serOutC(serOutC)
    );

    pog_pin_partner partner (
        .ref_clk(ref_clk), .fastEdgeClk(fastEdgeClk),
        .writeStrobeShiftedClk(writeStrobeShiftedClk), .serInA(serInA), .serInC(serInC),
        .serOutA(serOutA), .serOutC(serOutC)
    );

    task automatic complete_run();
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_word(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // next core word goes out just after the edge that sampled the previous one
    always @(posedge ref_clk)
    begin
        if (slowClkEn === 1'b1)
        begin
            txSent.push_back(txWord);
            txWord <= 8'($urandom);
        end
    end

    // deserialized words appear the cycle after the word strobe
    always @(posedge ref_clk)
    begin
        enLate <= slowClkEn;
        if (enLate === 1'b1 && rxQ.size() > 0)
            check_word("rxWord", {24'h0, rxQ.pop_front()}, {24'h0, rxWord});
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        logic [31:0] rd;
        logic        er, a, b, t;
        logic [7:0]  word, exp;
        int          nb, e, sl;
        void'($urandom(6922));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, pog_pkg::CTRL_OFFSET, 32'h0, rd, er);
        check_word("ctrl", pog_pkg::CTRL_RESET, rd);
        apb(1'b0, pog_pkg::STATUS_OFFSET, 32'h0, rd, er);
        check_bit("tsReg", 1'b1, rd[pog_pkg::TS_STATE_POS]);
        check_bit("padOe", 1'b0, padOe);
        apb(1'b1, 8'h08, 32'h1f, rd, er);
        check_bit("pslverr", 1'b1, er);
        apb(1'b1, pog_pkg::CTRL_OFFSET, 32'h1f, rd, er);
        apb(1'b0, pog_pkg::CTRL_OFFSET, 32'h0, rd, er);
        check_word("ctrl", 32'h1f, rd);
        // every output mode: rise (not memory mode), fall in single-rate register and generic modes, and, in memory mode, the write strobe
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, pog_pkg::CTRL_OFFSET, 32'(m), rd, er);
            a = 1'($urandom);
            b = ~a;
            t = 1'($urandom);
            firstCoreBit <= a;
            secondCoreBit <= b;
            tristateCtrlIn <= t;
            partner.set_pin_clk(1'b0, 1'b1);
            if (m != 3)
                check_bit("padOe", ~t, padOe);
            if (m == 1)
            begin
                firstCoreBit <= ~a;
                repeat (6) @(posedge ref_clk);
                check_bit("padOut", ~a, padOut);
            end
            else if (m != 3)
                check_bit("padOut", a, padOut);
            partner.set_pin_clk(1'b0, 1'b0);
            if (m == 0 || m == 2)
                check_bit("padOut", (m == 2) ? b : a, padOut);
            if (m == 3)
            begin
                partner.set_pin_clk(1'b1, 1'b1);
                check_bit("padOut", a, padOut);
                check_bit("padOe", ~t, padOe);
                partner.set_pin_clk(1'b1, 1'b0);
                check_bit("padOut", b, padOut);
            end
        end
        // each gear mode: six words in, three words out checked, framing restarted by gearRst;
        // the spare code runs as 1:8 and its frame opens with a one-bit slip
        for (int g = 0; g < 4; g++)
        begin
            nb = (g == 0) ? 7 : (g == 2) ? 4 : 8;
            sl = (g == 3) ? 1 : 0;
            apb(1'b1, pog_pkg::CTRL_OFFSET, 32'(g) << pog_pkg::GEAR_MODE_POS, rd, er);
            gearRst <= 1'b1;
            @(posedge ref_clk);
            gearRst <= 1'b0;
            wordAlignReq <= 1'(sl);
            @(posedge ref_clk);
            wordAlignReq <= 1'b0;
            txSent.delete();
            rxQ.push_back(pog_pkg::WORD_RESET);
            for (int w = 0; w < 6; w++)
            begin
                word = 8'($urandom);
                exp = 8'h00;
                for (int j = 0; j < nb; j++)
                begin
                    partner.bitsA[w * nb + j + sl] = word[j];
                    partner.bitsC[w * nb + j + sl] = word[7 - j];
                    exp[(g == 2) ? j + 4 : j] = word[j];
                    if (g == 2)
                        exp[j] = word[7 - j];
                end
                if (w < 5)
                    rxQ.push_back(exp);
            end
            partner.run_frame(6 * nb + sl);
            repeat (10) @(posedge ref_clk);
            check_word("rxPending", 32'h0, 32'(rxQ.size()));
            for (int w = 0; w < 3; w++)
                for (int j = 0; j < nb; j++)
                begin
                    e = nb * (w + 2) + j + sl;
                    check_bit("serOutA", txSent[w][j], partner.capA[e]);
                    if (g == 2)
                        check_bit("serOutC", txSent[w][j + 4], partner.capC[e]);
                end
        end
        complete_run();
    end

endmodule // tb_top
